// ==== hw/group_coord.sv ====
// group coordination: phase spreading, ordered turn-on/off, fault spreading, current share
// assumes management commands arrive on the cmd port on the device clock
`timescale 1ns/1ps
`include "group_cfg.svh"
module group_coord #(
  parameter int BIT_CYC = `LINK_BIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en_pin,
  input wire logic sync_pin,
  input wire logic link_in,
  output logic link_oe,
  output logic link_out,
  input wire logic [7:0] share_in,
  output logic [7:0] share_out,
  output logic share_oe,
  input wire logic [7:0] sensed_current,
  output logic [7:0] share_ref,
  input wire logic rail_good,
  input wire logic ramp_done,
  input wire logic fault_det,
  output logic run_out,
  output logic soft_off,
  output logic cycle_start,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ack,
  output logic cmd_err,
  output logic [15:0] cmd_rdata
);
  import group_pkg::*;

  function automatic logic [7:0] mk_msg(input msg_t t, input logic [4:0] a);
    mk_msg = {t, a};
  endfunction

  function automatic logic [4:0] auto_steps(input logic [3:0] n, input logic [2:0] p);
    logic [6:0] q;
    q = {p, 4'h0} / {3'h0, n};
    auto_steps = (q == 7'h0) ? `PHASE_STEPS : q[4:0];
  endfunction

  link_if lk();
  link_phy #(.BIT_CYC(BIT_CYC)) u_phy (
    .clk(clk),
    .nrst(nrst),
    .link_in(link_in),
    .link_oe(link_oe),
    .link_out(link_out),
    .lk(lk.phy)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic en_s1, en_s2, sy_s1, sy_s2, sy_s3;
  logic [7:0] sh_s1, sh_s2;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      sy_s1 <= 1'b0;
      sy_s2 <= 1'b0;
      sy_s3 <= 1'b0;
      sh_s1 <= 8'h00;
      sh_s2 <= 8'h00;
    end else begin
      en_s1 <= en_pin;
      en_s2 <= en_s1;
      sy_s1 <= sync_pin;
      sy_s2 <= sy_s1;
      sy_s3 <= sy_s2;
      sh_s1 <= share_in;
      sh_s2 <= sh_s1;
    end
  end

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  logic [15:0] role_reg, role_next, chain_reg, chain_next;
  logic [3:0] phase_reg, phase_next;
  logic [2:0] fresp_reg, fresp_next;
  logic flt_seen_reg, flt_seen_next;
  logic ack_next, err_next;
  logic [15:0] rdata_next;
  logic flt_event;
  seq_state_t st_reg, st_next;

  always_comb begin
    role_next = role_reg;
    chain_next = chain_reg;
    phase_next = phase_reg;
    fresp_next = fresp_reg;
    flt_seen_next = flt_seen_reg;
    ack_next = cmd_valid;
    err_next = 1'b0;
    rdata_next = 16'h0000;
    case (cmd_code)
      `ROLE_CODE: begin
        rdata_next = role_reg;
        if (cmd_valid && cmd_write) role_next = cmd_wdata & `ROLE_MASK;
      end
      `PHASE_CODE: begin
        rdata_next = {12'h000, phase_reg};
        if (cmd_valid && cmd_write) phase_next = cmd_wdata[3:0];
      end
      `CHAIN_CODE: begin
        rdata_next = chain_reg;
        if (cmd_valid && cmd_write) chain_next = cmd_wdata & `CHAIN_MASK;
      end
      `FRESP_CODE: begin
        rdata_next = {13'h0000, fresp_reg};
        if (cmd_valid && cmd_write) fresp_next = cmd_wdata[2:0];
      end
      `STATUS_CODE: begin
        rdata_next = {11'h000, flt_seen_reg, st_reg, en_s2};
        if (cmd_valid && cmd_write && cmd_wdata[`STAT_FLT_BIT]) flt_seen_next = 1'b0;
      end
      default: begin
        err_next = cmd_valid;
      end
    endcase
    if (flt_event) flt_seen_next = 1'b1;
    if (!cmd_valid) rdata_next = cmd_rdata;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      role_reg <= `ROLE_RST;
      chain_reg <= `CHAIN_RST;
      phase_reg <= `PHASE_RST;
      fresp_reg <= `FRESP_RST;
      flt_seen_reg <= 1'b0;
      cmd_ack <= 1'b0;
      cmd_err <= 1'b0;
      cmd_rdata <= 16'h0000;
    end else begin
      role_reg <= role_next;
      chain_reg <= chain_next;
      phase_reg <= phase_next;
      fresp_reg <= fresp_next;
      flt_seen_reg <= flt_seen_next;
      cmd_ack <= ack_next;
      cmd_err <= err_next;
      cmd_rdata <= rdata_next;
    end
  end

  logic [4:0] own_id, pre_id, seq_id;
  logic share_en, is_master, msg_mode, need_pre, need_seq;
  logic [3:0] members;
  assign own_id = role_reg[4:0];
  assign share_en = role_reg[`ROLE_SHARE_BIT];
  assign is_master = role_reg[`ROLE_MASTER_BIT];
  assign members = {1'b0, role_reg[9:7]} + 4'h1;
  assign pre_id = chain_reg[4:0];
  assign seq_id = chain_reg[9:5];
  assign msg_mode = ~chain_reg[`CHAIN_TIMER_BIT];
  assign need_pre = chain_reg[`CHAIN_HASPRE_BIT] & msg_mode;
  assign need_seq = chain_reg[`CHAIN_HASSEQ_BIT] & msg_mode;

  // ----------------------------------------------------------------
  // phase spreading
  // ----------------------------------------------------------------
  logic sync_edge;
  logic [4:0] steps;
  logic [20:0] prod;
  logic [15:0] per_cnt_reg, per_cnt_next, per_reg, per_next, dly_reg, dly_next;
  logic cyc_next;

  always_comb begin
    sync_edge = sy_s2 & ~sy_s3;
    // auto offset in a sharing rail
    steps = share_en ? auto_steps(members, role_reg[12:10]) : {1'b0, phase_reg} + 5'h1;
    // delay is period times steps over sixteen
    prod = {5'h00, per_reg} * {16'h0000, steps};
    per_cnt_next = (per_cnt_reg == 16'hffff) ? per_cnt_reg : per_cnt_reg + 16'h1;
    per_next = per_reg;
    dly_next = (dly_reg != 16'h0) ? dly_reg - 16'h1 : dly_reg;
    if (sync_edge) begin
      per_cnt_next = 16'h0;
      per_next = per_cnt_reg + 16'h1;
      dly_next = prod[19:4];
    end
    cyc_next = (dly_reg == 16'h1);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      per_cnt_reg <= 16'h0;
      per_reg <= 16'h0;
      dly_reg <= 16'h0;
      cycle_start <= 1'b0;
    end else begin
      per_cnt_reg <= per_cnt_next;
      per_reg <= per_next;
      dly_reg <= dly_next;
      cycle_start <= cyc_next;
    end
  end

  // ----------------------------------------------------------------
  // sequencing and fault spreading
  // ----------------------------------------------------------------
  logic got_good, got_off, got_fault, local_fault, active;
  logic set_good, set_off, set_fault;
  logic pend_good_reg, pend_off_reg, pend_flt_reg;
  logic pend_good_next, pend_off_next, pend_flt_next;
  logic txv_reg, txv_next;
  logic [7:0] txw_reg, txw_next;
  logic run_next, soft_next;

  always_comb begin
    got_good = lk.rx_valid && lk.rx_word == mk_msg(MSG_GOOD, own_id);
    got_off = lk.rx_valid && lk.rx_word == mk_msg(MSG_OFF, own_id);
    got_fault = lk.rx_valid && lk.rx_word[7:5] == MSG_FAULT && fresp_reg[`FRESP_SPREAD_BIT];
    active = (st_reg != ST_OFF) && (st_reg != ST_FAULT);
    local_fault = fault_det && fresp_reg[`FRESP_SHUT_BIT] && active;
    st_next = st_reg;
    set_good = 1'b0;
    set_off = 1'b0;
    set_fault = 1'b0;
    case (st_reg)
      ST_OFF: if (en_s2) st_next = need_pre ? ST_WAIT_PREQ : ST_RAMP_UP;
      ST_WAIT_PREQ: begin
        if (!en_s2) st_next = ST_OFF;
        else if (got_good) st_next = ST_RAMP_UP;
      end
      ST_RAMP_UP: begin
        if (!en_s2) st_next = need_seq ? ST_WAIT_SEQ : ST_RAMP_DOWN;
        else if (rail_good) begin
          st_next = ST_ON;
          set_good = need_seq;
        end
      end
      ST_ON: if (!en_s2) st_next = need_seq ? ST_WAIT_SEQ : ST_RAMP_DOWN;
      // prequel holds until its sequel is down
      ST_WAIT_SEQ: begin
        if (got_off) st_next = ST_RAMP_DOWN;
        else if (en_s2) st_next = ST_ON;
      end
      ST_RAMP_DOWN: begin
        if (ramp_done) begin
          st_next = ST_OFF;
          set_off = need_pre;
        end
      end
      // restart in order once the broadcast is out
      ST_FAULT: begin
        if (!en_s2) st_next = ST_OFF;
        else if (fresp_reg[`FRESP_RESTART_BIT] && !pend_flt_reg && !txv_reg && !fault_det)
          st_next = need_pre ? ST_WAIT_PREQ : ST_RAMP_UP;
      end
      default: st_next = ST_OFF;
    endcase
    if (local_fault) begin
      st_next = ST_FAULT;
      set_fault = 1'b1;
    end else if (got_fault && active) begin
      st_next = ST_FAULT;
    end
    flt_event = local_fault | (got_fault & active);
    run_next = (st_next == ST_RAMP_UP) || (st_next == ST_ON) || (st_next == ST_WAIT_SEQ);
    soft_next = (st_next == ST_RAMP_DOWN);
    // transmit queue: fault first, set wins over clear
    txv_next = txv_reg & ~lk.tx_ready;
    txw_next = txw_reg;
    pend_flt_next = pend_flt_reg;
    pend_off_next = pend_off_reg;
    pend_good_next = pend_good_reg;
    if (!txv_reg) begin
      if (pend_flt_reg) begin
        txv_next = 1'b1;
        txw_next = mk_msg(MSG_FAULT, `BCAST_ADDR);
        pend_flt_next = 1'b0;
      end else if (pend_off_reg) begin
        txv_next = 1'b1;
        txw_next = mk_msg(MSG_OFF, pre_id);
        pend_off_next = 1'b0;
      end else if (pend_good_reg) begin
        txv_next = 1'b1;
        txw_next = mk_msg(MSG_GOOD, seq_id);
        pend_good_next = 1'b0;
      end
    end
    pend_flt_next = pend_flt_next | set_fault;
    pend_off_next = pend_off_next | set_off;
    pend_good_next = pend_good_next | set_good;
  end

  assign lk.tx_valid = txv_reg;
  assign lk.tx_word = txw_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= ST_OFF;
      pend_good_reg <= 1'b0;
      pend_off_reg <= 1'b0;
      pend_flt_reg <= 1'b0;
      txv_reg <= 1'b0;
      txw_reg <= 8'h00;
      run_out <= 1'b0;
      soft_off <= 1'b0;
    end else begin
      st_reg <= st_next;
      pend_good_reg <= pend_good_next;
      pend_off_reg <= pend_off_next;
      pend_flt_reg <= pend_flt_next;
      txv_reg <= txv_next;
      txw_reg <= txw_next;
      run_out <= run_next;
      soft_off <= soft_next;
    end
  end

  // ----------------------------------------------------------------
  // current share line
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      share_out <= 8'h00;
      share_oe <= 1'b0;
      share_ref <= 8'h00;
    end else begin
      share_out <= sensed_current;
      share_oe <= share_en & is_master;
      share_ref <= (share_en & is_master) ? sensed_current : sh_s2;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] since_reg, ldly_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_reg <= 16'h0;
      ldly_reg <= 16'h0;
    end else begin
      since_reg <= sync_edge ? 16'h1 : since_reg + 16'h1;
      if (sync_edge) ldly_reg <= prod[19:4];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  phase_delay_a: assert property (cycle_start && !$past(sync_edge) |-> since_reg == ldly_reg + 16'h1)
    else $error("cycle start not at phase delay");
  ordered_off_a: assert property (st_reg == ST_ON && !en_s2 && !flt_event |=> st_reg inside {ST_WAIT_SEQ, ST_RAMP_DOWN} && (run_out || soft_off))
    else $error("enable low did not start ordered turn-off");
  good_msg_a: assert property (st_reg == ST_RAMP_UP && en_s2 && rail_good && need_seq && !flt_event |=> pend_good_reg)
    else $error("rail good did not queue sequel message");
  wait_preq_a: assert property (st_reg == ST_WAIT_PREQ |=> !run_out || $past(got_good))
    else $error("sequel ramped before prequel message");
  off_msg_a: assert property (st_reg == ST_RAMP_DOWN && ramp_done && need_pre && !flt_event |=> pend_off_reg ##1 !run_out)
    else $error("ramp down end did not queue prequel message");
  timer_start_a: assert property (st_reg == ST_OFF && en_s2 && !need_pre |=> st_reg == ST_RAMP_UP && run_out)
    else $error("timer-only start did not ramp");
  fault_bcast_a: assert property (local_fault |=> st_reg == ST_FAULT && pend_flt_reg ##1 !run_out)
    else $error("local fault not shut down and broadcast");
  rx_fault_a: assert property (got_fault && active |=> st_reg == ST_FAULT)
    else $error("received fault ignored");
  share_drive_a: assert property ($rose(share_en & is_master) |=> share_oe [*2])
    else $error("master not driving share line");
  share_ref_a: assert property (share_en && !is_master |=> share_ref == $past(sh_s2))
    else $error("slave reference not from share line");

  seq_full_c: cover property (st_reg == ST_WAIT_PREQ ##[1:1000] st_reg == ST_ON);
  off_seq_c: cover property (st_reg == ST_WAIT_SEQ ##[1:1000] st_reg == ST_OFF);
  fault_c: cover property (st_reg == ST_FAULT ##[1:1000] st_reg == ST_RAMP_UP);

endmodule

// ==== hw/link_phy.sv ====
// serialiser and deserialiser for the open-drain group link
// assumes an external pull-up; the line idles high
`timescale 1ns/1ps
`include "group_cfg.svh"
module link_phy #(
  parameter int BIT_CYC = `LINK_BIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_in,
  output logic link_oe,
  output logic link_out,
  link_if.phy lk
);
  import group_pkg::*;

  // ----------------------------------------------------------------
  // transmit: start bit low, eight bits lsb first, stop bit high
  // ----------------------------------------------------------------
  logic tx_busy_reg, tx_busy_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [9:0] tx_sh_reg, tx_sh_next;
  logic oe_next;

  always_comb begin
    tx_busy_next = tx_busy_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    if (!tx_busy_reg) begin
      if (lk.tx_valid) begin
        tx_busy_next = 1'b1;
        tx_sh_next = {1'b1, lk.tx_word, 1'b0};
        tx_cnt_next = 16'(BIT_CYC - 1);
        tx_bit_next = 4'h9;
      end
    end else if (tx_cnt_reg == 16'h0) begin
      if (tx_bit_reg == 4'h0) begin
        tx_busy_next = 1'b0;
      end else begin
        tx_sh_next = {1'b1, tx_sh_reg[9:1]};
        tx_bit_next = tx_bit_reg - 4'h1;
        tx_cnt_next = 16'(BIT_CYC - 1);
      end
    end else begin
      tx_cnt_next = tx_cnt_reg - 16'h1;
    end
    oe_next = tx_busy_next & ~tx_sh_next[0];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= 16'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3ff;
      link_oe <= 1'b0;
      link_out <= 1'b0;
    end else begin
      tx_busy_reg <= tx_busy_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      link_oe <= oe_next;
      link_out <= 1'b0;
    end
  end

  assign lk.tx_ready = ~tx_busy_reg;

  // ----------------------------------------------------------------
  // receive: sample at bit centres, keep word only on a good stop bit
  // ----------------------------------------------------------------
  logic s1_reg, s2_reg;
  logic rx_busy_reg, rx_busy_next;
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic rx_valid_reg, rx_valid_next;

  always_comb begin
    rx_busy_next = rx_busy_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_valid_next = 1'b0;
    if (!rx_busy_reg) begin
      if (!s2_reg) begin
        rx_busy_next = 1'b1;
        rx_cnt_next = 16'(BIT_CYC / 2);
        rx_bit_next = 4'h0;
      end
    end else if (rx_cnt_reg == 16'h0) begin
      rx_cnt_next = 16'(BIT_CYC - 1);
      rx_bit_next = rx_bit_reg + 4'h1;
      if (rx_bit_reg == 4'h0) begin
        rx_busy_next = ~s2_reg;
      end else if (rx_bit_reg == 4'h9) begin
        rx_busy_next = 1'b0;
        rx_valid_next = s2_reg;
      end else begin
        rx_sh_next = {s2_reg, rx_sh_reg[7:1]};
      end
    end else begin
      rx_cnt_next = rx_cnt_reg - 16'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 16'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else begin
      s1_reg <= link_in;
      s2_reg <= s1_reg;
      rx_busy_reg <= rx_busy_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

  assign lk.rx_valid = rx_valid_reg;
  assign lk.rx_word = rx_sh_reg;

endmodule

// ==== inc/group_cfg.svh ====
// constants for the group coordination block: command codes, field positions, reset values
// assumes a 250 MHz device clock and an open-drain single-wire group link
//
// Notes on behaviour
// - phase offset 22.5 to 360 degrees in 22.5 steps delays each cycle start.
// - software sets prequel and sequel identities; messages are addressed with them.
// - shared enable going low starts an ordered turn-off, not an instant stop.
// - prequel messages its sequel when rail good rises; sequel waits before ramping.
// - sequel finishes its ramp down, then messages prequel, which then ramps down.
// - in timer-only ordering the device starts on its own timers regardless.
// - a fault set to shut down stops the output and broadcasts on the link.
// - a received fault shuts down if configured, then restarts in order if configured.
// - up to eight paralleled devices form one current sharing rail.
// - sharing role, master or slave, is set by the command at code d3h.
// - master drives its sensed current on the share line; slaves use it as reference.
// - in a sharing rail the phase offset follows the rail's member count.
`ifndef GROUP_CFG_SVH
`define GROUP_CFG_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define ROLE_CODE 8'hd3
`define PHASE_CODE 8'hd8
`define CHAIN_CODE 8'he0
`define FRESP_CODE 8'he1
`define STATUS_CODE 8'he2

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define ROLE_RST 16'h0000
`define ROLE_MASK 16'h1fff
`define PHASE_RST 4'hf
`define CHAIN_RST 16'h0000
`define CHAIN_MASK 16'h1fff
`define FRESP_RST 3'h1
`define ROLE_SHARE_BIT 5
`define ROLE_MASTER_BIT 6
`define CHAIN_HASPRE_BIT 10
`define CHAIN_HASSEQ_BIT 11
`define CHAIN_TIMER_BIT 12
`define FRESP_SHUT_BIT 0
`define FRESP_SPREAD_BIT 1
`define FRESP_RESTART_BIT 2
`define STAT_FLT_BIT 4
`define BCAST_ADDR 5'h1f
`define PHASE_STEPS 5'd16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 250
`define LINK_BIT_NS 1000
`define LINK_BIT_CYC ((`LINK_BIT_NS * `CLK_MHZ) / 1000)

`endif

// ==== inc/group_pkg.sv ====
// types shared by the group coordination block
// assumes group_cfg.svh for all numeric constants
package group_pkg;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_WAIT_PREQ = 3'b001,
    ST_RAMP_UP = 3'b011,
    ST_ON = 3'b010,
    ST_WAIT_SEQ = 3'b110,
    ST_RAMP_DOWN = 3'b111,
    ST_FAULT = 3'b101
  } seq_state_t;

  typedef enum logic [2:0] {
    MSG_NONE = 3'h0,
    MSG_GOOD = 3'h1,
    MSG_OFF = 3'h2,
    MSG_FAULT = 3'h3
  } msg_t;

endpackage

// ==== inc/link_if.sv ====
// word handshake between the sequencing core and the link serialiser
// assumes both ends on the device clock
`timescale 1ns/1ps
interface link_if;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_word;
  logic rx_valid;
  logic [7:0] rx_word;
  modport core(output tx_valid, output tx_word, input tx_ready, input rx_valid, input rx_word);
  modport phy(input tx_valid, input tx_word, output tx_ready, output rx_valid, output rx_word);
endinterface

// ==== testbench/link_partner.sv ====
// partner controller on the open-drain group link
// assumes a pull-up on the wire; frames of BIT_CYC cycles a bit
`timescale 1ns/1ps
module link_partner #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk,
  input wire logic dut_oe,
  output logic line,
  output logic [7:0] rx_word,
  output int rx_cnt
);
  logic oe = 1'b0;
  assign line = !(dut_oe | oe);
  // start low, lsb first, stop high
  task automatic send(input logic [7:0] w);
    oe = 1'b1;
    for (int i = 0; i <= 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      #1 oe = (i < 8) ? !w[i] : 1'b0;
    end
    repeat (BIT_CYC) @(posedge clk);
    #1;
  endtask
  initial rx_cnt = 0;
  always begin
    @(negedge line);
    if (!oe) begin
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        rx_word[i] = line;
      end
      repeat (BIT_CYC) @(posedge clk);
      rx_cnt++;
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// bench for the group coordination block
// assumes the partner model on the link and a 250 MHz clock
`timescale 1ns/1ps
`define chk(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk = 0, nrst = 0, en_pin = 0, sync_pin = 0, rail_good = 0;
  logic ramp_done = 0, fault_det = 0, cmd_valid = 0, cmd_write = 0;
  logic [7:0] cmd_code = 8'h00, share_in = 8'h00, sensed_current = 8'h00;
  logic [7:0] share_out, share_ref, rx_word;
  logic [15:0] cmd_wdata = 16'h0000, cmd_rdata, rd;
  logic link_oe, link_out, link_line, share_oe, run_out, soft_off;
  logic cycle_start, cmd_ack, cmd_err, ak, er;
  int errors = 0, n_tests = 0, cyc = 0, rx_cnt, n;

  group_coord #(.BIT_CYC(8)) dut_u (.clk, .nrst, .en_pin, .sync_pin,
    .link_in(link_line), .link_oe, .link_out, .share_in, .share_out, .share_oe,
    .sensed_current, .share_ref, .rail_good, .ramp_done, .fault_det, .run_out,
    .soft_off, .cycle_start, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .cmd_ack, .cmd_err, .cmd_rdata);
  link_partner #(.BIT_CYC(8)) lp_u (.clk, .dut_oe(link_oe), .line(link_line),
    .rx_word, .rx_cnt);

  initial forever #2 clk = !clk;
  // sync and share lines shared with the rail
  always begin
    repeat (40) @(posedge clk);
    #1 sync_pin = !sync_pin;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #1 {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    {ak, er, rd} = {cmd_ack, cmd_err, cmd_rdata};
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    cmd(1'b0, c, 16'h0000);
    `chk({ak, er, rd}, {2'b10, e})
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_rx;
    for (int i = 0; i < 300 && rx_cnt == n; i++) @(posedge clk);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    tick(12);
    nrst = 1'b1;
    rchk(8'hd3, 16'h0000);
    rchk(8'hd8, 16'h000f);
    rchk(8'he0, 16'h0000);
    cmd(1'b0, 8'h55, 16'h0000);
    `chk({ak, er, rd}, {2'b11, 16'h0000})
    cmd(1'b1, 8'hd3, 16'hffff);
    rchk(8'hd3, 16'h1fff);
    cmd(1'b1, 8'hd8, 16'h0000);
    rchk(8'hd8, 16'h0000);
    done("regs");
    tick(100);
    n = 0;
    repeat (80) begin
      @(posedge clk);
      #1 n += cycle_start;
    end
    `chk(n, 1)
    `chk(link_out, 1'b0)
    cmd(1'b1, 8'hd3, 16'h0060);
    sensed_current = 8'h5a;
    tick(3);
    `chk({share_oe, share_out, share_ref}, {1'b1, 8'h5a, 8'h5a})
    cmd(1'b1, 8'hd3, 16'h0020);
    share_in = 8'h33;
    tick(4);
    `chk({share_oe, share_ref}, {1'b0, 8'h33})
    done("share");
    cmd(1'b1, 8'he0, 16'h1400);
    en_pin = 1'b1;
    tick(6);
    `chk(run_out, 1'b1)
    en_pin = 1'b0;
    tick(6);
    `chk(soft_off, 1'b1)
    rchk(8'he2, 16'h000e);
    ramp_done = 1'b1;
    tick(90);
    ramp_done = 1'b0;
    done("timer");
    cmd(1'b1, 8'he0, 16'h0400);
    en_pin = 1'b1;
    tick(6);
    rchk(8'he2, 16'h0003);
    `chk(run_out, 1'b0)
    lp_u.send(8'h20);
    tick(4);
    `chk(run_out, 1'b1)
    en_pin = 1'b0;
    tick(6);
    n = rx_cnt;
    ramp_done = 1'b1;
    wait_rx();
    ramp_done = 1'b0;
    `chk(rx_word, 8'h40)
    done("sequel");
    cmd(1'b1, 8'he0, 16'h08a0);
    en_pin = 1'b1;
    tick(6);
    n = rx_cnt;
    rail_good = 1'b1;
    wait_rx();
    `chk(rx_word, 8'h25)
    en_pin = 1'b0;
    tick(6);
    rchk(8'he2, 16'h000c);
    lp_u.send(8'h40);
    tick(4);
    `chk(soft_off, 1'b1)
    {ramp_done, rail_good} = 2'b10;
    tick(90);
    ramp_done = 1'b0;
    done("prequel");
    cmd(1'b1, 8'he0, 16'h0000);
    cmd(1'b1, 8'he1, 16'h0003);
    en_pin = 1'b1;
    tick(6);
    lp_u.send(8'h7f);
    tick(4);
    `chk(run_out, 1'b0)
    en_pin = 1'b0;
    tick(6);
    en_pin = 1'b1;
    tick(6);
    n = rx_cnt;
    fault_det = 1'b1;
    tick(3);
    `chk(run_out, 1'b0)
    wait_rx();
    `chk(rx_word, 8'h7f)
    done("fault");
    stop_test();
  end
endmodule
